// >>> src/uom_cfg.svh
// Constants for the OAM connectivity and delay message ends: field codes,
// lengths, bit positions and timestamp timing. Assumes a 40 MHz core clock.
`ifndef UOM_CFG_SVH
`define UOM_CFG_SVH

// Message type and code values
`define UOM_TYPE_QUERY 8'h00
`define UOM_TYPE_REPLY 8'h08
`define UOM_QCODE_VALIDATE 8'h00
`define UOM_QCODE_NOVAL 8'h01
`define UOM_RCODE_ACK 8'h00
`define UOM_RCODE_INVALID 8'h01

// Message length in bytes, without and with the three timestamps
`define UOM_LEN_BASIC 16'h0010
`define UOM_LEN_DELAY 16'h001C

// Service-specific field positions for AAL1
`define UOM_SSI_SLOTS_LSB 16
`define UOM_SSI_PDUS_LSB 24

// Size of the OAM identifier table at the replying end
`define UOM_OAM_IDS 4

// Reflected CRC-32 over each 32-bit word, LSB first
`define UOM_CRC_INIT 32'hFFFFFFFF
`define UOM_CRC_POLY 32'hEDB88320

// Timestamp resolution in ns, converted to clock cycles
`define UOM_CLK_NS 25
`define UOM_TS_FINE_NS 1000
`define UOM_TS_COARSE_NS 100000
`define UOM_TS_FINE_CYC (`UOM_TS_FINE_NS / `UOM_CLK_NS)
`define UOM_TS_COARSE_CYC (`UOM_TS_COARSE_NS / `UOM_CLK_NS)

`endif

// >>> src/uom_pkg.sv
// Types and helpers shared by both message ends.
// Assumes the constants header is on the include path.
`include "uom_cfg.svh"

package uom_pkg;

  // Word positions within one framed message
  typedef enum logic [3:0] {
    W_ETH, W_VLAN, W_CTRL, W_SEQ, W_SSI, W_BID, W_TS0, W_TS1, W_TS2, W_CRC
  } uom_word_e;

  // Defect and modifier flags of the bundle under test
  typedef struct packed {
    logic loss;
    logic remote;
    logic [1:0] modifier;
  } uom_flags_s;

  // Order of words; VLAN and timestamps are skipped when absent
  function automatic uom_word_e uom_next_word(input uom_word_e cur, input logic vlan, input logic dly);
    case (cur)
      W_ETH: return vlan ? W_VLAN : W_CTRL;
      W_BID: return dly ? W_TS0 : W_CRC;
      W_CRC: return W_ETH;
      default: return uom_word_e'(cur + 4'h1);
    endcase
  endfunction

  // Bitwise CRC-32 step over one word
  function automatic logic [31:0] uom_crc(input logic [31:0] crc, input logic [31:0] word);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 32; i++) begin
      c = (c >> 1) ^ ((c[0] ^ word[i]) ? `UOM_CRC_POLY : 32'h0);
    end
    return c;
  endfunction

  // Flags plus byte length of the message
  function automatic logic [31:0] uom_ctrl_word(input uom_flags_s f, input logic dly);
    return {4'h0, f, 8'h00, dly ? `UOM_LEN_DELAY : `UOM_LEN_BASIC};
  endfunction

  // Service field: zero unless configuration is exchanged
  function automatic logic [31:0] uom_ssi(input logic en, input logic [7:0] slots, input logic [7:0] pdus);
    return en ? {pdus, slots, 16'h0000} : 32'h0;
  endfunction

  // Last tick count of one timestamp unit
  function automatic logic [11:0] uom_tick_last(input logic coarse);
    return coarse ? 12'(`UOM_TS_COARSE_CYC - 1) : 12'(`UOM_TS_FINE_CYC - 1);
  endfunction

endpackage

// >>> src/uom_link_if.sv
// Packet link between the querying and replying gateways.
// Words flow with valid/ready; last marks the CRC word of a message.
`timescale 1ns/1ps
`default_nettype none

interface uom_link_if;
  logic [31:0] q2r_data;
  logic q2r_last;
  logic q2r_valid;
  logic q2r_ready;
  logic [31:0] r2q_data;
  logic r2q_last;
  logic r2q_valid;
  logic r2q_ready;

  modport query_end (
    output q2r_data, q2r_last, q2r_valid, r2q_ready,
    input q2r_ready, r2q_data, r2q_last, r2q_valid
  );

  modport reply_end (
    output r2q_data, r2q_last, r2q_valid, q2r_ready,
    input r2q_ready, q2r_data, q2r_last, q2r_valid
  );
endinterface

`default_nettype wire

// >>> src/uom_query_end.sv
// Querying gateway: builds connectivity queries and parses the replies.
// Assumes user inputs are on sys_clk_in and stay stable during a query.
`timescale 1ns/1ps
`default_nettype none
`include "uom_cfg.svh"

module uom_query_end (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  uom_link_if.query_end link,
  input wire logic start_in,
  input wire logic validate_in,
  input wire logic delay_en_in,
  input wire logic ts_coarse_in,
  input wire uom_pkg::uom_flags_s flags_in,
  input wire logic [15:0] oam_bid_in,
  input wire logic [15:0] tx_bid_in,
  input wire logic [15:0] rx_bid_in,
  input wire logic ssi_en_in,
  input wire logic [7:0] slots_in,
  input wire logic [7:0] pdus_in,
  input wire logic [15:0] ethertype_in,
  input wire logic vlan_en_in,
  input wire logic [31:0] vlan_tag_in,
  output logic busy_out,
  output logic reply_valid_out,
  output logic reply_code_out,
  output logic [15:0] reply_seq_out,
  output logic seq_err_out,
  output logic [31:0] ts_src_tx_out,
  output logic [31:0] ts_dst_rx_out,
  output logic [31:0] ts_dst_tx_out,
  output logic [31:0] ts_src_rx_out
);
  import uom_pkg::*;

  typedef struct packed {
    // Timestamp base
    logic [11:0] tick;
    logic [31:0] ts;
    // Builder
    logic bld;
    uom_word_e widx;
    logic [31:0] crc;
    logic [15:0] seq;
    logic [7:0] code;
    logic dly;
    logic [31:0] ts_sent;
    // Two-entry transmit buffer
    logic [1:0][32:0] buff;
    logic [1:0] cnt;
    logic tx_valid;
    // Parser
    logic rx_ready;
    uom_word_e ridx;
    logic [31:0] rcrc;
    logic rbad;
    logic rdly;
    logic [31:0] rw1;
    logic [31:0] rts0;
    logic [31:0] rts1;
    logic [31:0] rts2;
    logic [31:0] rts_rx;
    // Results
    logic reply_valid;
    logic reply_code;
    logic [15:0] reply_seq;
    logic seq_err;
    logic [31:0] o_src_tx;
    logic [31:0] o_dst_rx;
    logic [31:0] o_dst_tx;
    logic [31:0] o_src_rx;
  } uom_qry_s;

  uom_qry_s s;
  uom_qry_s next_s;
  logic [31:0] word;
  logic [31:0] w;
  logic pop;
  logic push;

  // Next-state logic for the whole end
  always_comb begin
    next_s = s;
    next_s.reply_valid = 1'h0;
    next_s.rx_ready = 1'h1;
    w = link.r2q_data;

    // Free-running timestamp at 1 us or 100 us per count
    if (s.tick >= uom_tick_last(ts_coarse_in)) begin
      next_s.tick = 12'h000;
      next_s.ts = s.ts + 32'h1;
    end else begin
      next_s.tick = s.tick + 12'h001;
    end

    // New query: fresh sequence, send time captured now
    if (start_in && !s.bld) begin
      next_s.bld = 1'h1;
      next_s.widx = W_ETH;
      next_s.crc = `UOM_CRC_INIT;
      next_s.seq = s.seq + 16'h0001;
      next_s.dly = delay_en_in;
      next_s.ts_sent = s.ts;
      next_s.code = validate_in ? `UOM_QCODE_VALIDATE : `UOM_QCODE_NOVAL;
    end

    // Word being built; layers match the bundle's data packets
    case (s.widx)
      W_ETH: word = {ethertype_in, oam_bid_in};
      W_VLAN: word = vlan_tag_in;
      W_CTRL: word = uom_ctrl_word(flags_in, s.dly);
      W_SEQ: word = {s.seq, `UOM_TYPE_QUERY, s.code};
      W_SSI: word = uom_ssi(ssi_en_in, slots_in, pdus_in);
      W_BID: word = {tx_bid_in, rx_bid_in};
      W_TS0: word = s.ts_sent;
      W_CRC: word = ~s.crc;
      default: word = 32'h0; // Far-end stamps left for the replier
    endcase

    // Buffer: a stalled link fills it, and a full buffer stalls the builder
    pop = s.tx_valid && link.q2r_ready;
    push = s.bld && (s.cnt != 2'h2 || pop);
    if (pop) begin
      next_s.buff[0] = s.buff[1];
      next_s.cnt = s.cnt - 2'h1;
    end
    if (push) begin
      next_s.buff[next_s.cnt[0]] = {s.widx == W_CRC, word};
      next_s.cnt = next_s.cnt + 2'h1;
      next_s.crc = uom_crc(s.crc, word);
      next_s.widx = uom_next_word(s.widx, vlan_en_in, s.dly);
      if (s.widx == W_CRC) begin
        next_s.bld = 1'h0;
      end
    end
    next_s.tx_valid = next_s.cnt != 2'h0;

    // Reply parser; never stalls, so ready is held high
    if (link.r2q_valid && s.rx_ready) begin
      case (s.ridx)
        W_ETH: begin
          next_s.rbad = w != {ethertype_in, oam_bid_in};
          next_s.rts_rx = s.ts;
        end
        W_CTRL: next_s.rdly = w[15:0] == `UOM_LEN_DELAY;
        W_SEQ: next_s.rw1 = w;
        W_TS0: next_s.rts0 = w;
        W_TS1: next_s.rts1 = w;
        W_TS2: next_s.rts2 = w;
        W_CRC: begin
          // Only a clean reply of the right type is reported
          if (!s.rbad && w == ~s.rcrc && s.rw1[15:8] == `UOM_TYPE_REPLY) begin
            next_s.reply_valid = 1'h1;
            next_s.reply_code = s.rw1[7:0] == `UOM_RCODE_INVALID;
            next_s.reply_seq = s.rw1[31:16];
            next_s.seq_err = s.rw1[31:16] != s.seq;
            next_s.o_src_tx = s.rdly ? s.rts0 : 32'h0;
            next_s.o_dst_rx = s.rdly ? s.rts1 : 32'h0;
            next_s.o_dst_tx = s.rdly ? s.rts2 : 32'h0;
            next_s.o_src_rx = s.rdly ? s.rts_rx : 32'h0;
          end
        end
        default: ;
      endcase
      next_s.rcrc = uom_crc(s.rcrc, w);
      next_s.ridx = uom_next_word(s.ridx, vlan_en_in, next_s.rdly);
      // Last word always resynchronises, so a short packet cannot skew the next
      if (link.r2q_last) begin
        next_s.ridx = W_ETH;
        next_s.rcrc = `UOM_CRC_INIT;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
      s.rcrc <= `UOM_CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign link.q2r_data = s.buff[0][31:0];
  assign link.q2r_last = s.buff[0][32];
  assign link.q2r_valid = s.tx_valid;
  assign link.r2q_ready = s.rx_ready;
  assign busy_out = s.bld;
  assign reply_valid_out = s.reply_valid;
  assign reply_code_out = s.reply_code;
  assign reply_seq_out = s.reply_seq;
  assign seq_err_out = s.seq_err;
  assign ts_src_tx_out = s.o_src_tx;
  assign ts_dst_rx_out = s.o_dst_rx;
  assign ts_dst_tx_out = s.o_dst_tx;
  assign ts_src_rx_out = s.o_src_rx;

endmodule // uom_query_end

`default_nettype wire

// >>> src/uom_reply_end.sv
// Replying gateway: parses queries, checks configuration, sends replies.
// Assumes user inputs are on sys_clk_in and static while traffic runs.
`timescale 1ns/1ps
`default_nettype none
`include "uom_cfg.svh"

module uom_reply_end (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  uom_link_if.reply_end link,
  input wire logic ts_coarse_in,
  input wire uom_pkg::uom_flags_s flags_in,
  input wire logic [`UOM_OAM_IDS-1:0][15:0] oam_ids_in,
  input wire logic [15:0] tx_bid_in,
  input wire logic [15:0] rx_bid_in,
  input wire logic ssi_en_in,
  input wire logic [7:0] slots_in,
  input wire logic [7:0] pdus_in,
  input wire logic [15:0] ethertype_in,
  input wire logic vlan_en_in,
  input wire logic [31:0] vlan_tag_in,
  output logic query_valid_out,
  output logic mismatch_out,
  output logic [15:0] query_seq_out
);
  import uom_pkg::*;

  typedef struct packed {
    logic [11:0] tick;
    logic [31:0] ts;
    logic bld;
    uom_word_e widx;
    logic [31:0] crc;
    logic [15:0] seq;
    logic [7:0] code;
    logic dly;
    logic [15:0] bid;
    logic [31:0] ts0;
    logic [31:0] ts1;
    logic [31:0] ts2;
    logic [1:0][32:0] buff;
    logic [1:0] cnt;
    logic tx_valid;
    logic rx_ready;
    uom_word_e ridx;
    logic [31:0] rcrc;
    logic rbad;
    logic rdly;
    logic [15:0] rbid;
    logic [31:0] rw1;
    logic [31:0] rssi;
    logic [31:0] rbids;
    logic [31:0] rts0;
    logic [31:0] rts_rx;
    logic query_valid;
    logic mismatch;
    logic [15:0] query_seq;
  } uom_rep_s;

  uom_rep_s s;
  uom_rep_s next_s;
  logic [31:0] word;
  logic [31:0] w;
  logic pop;
  logic push;
  logic id_ok;
  logic bad_cfg;

  // Next-state logic for the whole end
  always_comb begin
    next_s = s;
    next_s.query_valid = 1'h0;
    next_s.rx_ready = 1'h1;
    w = link.q2r_data;
    // Identifier must be one of the OAM-reserved entries
    id_ok = 1'h0;
    for (int i = 0; i < `UOM_OAM_IDS; i++) begin
      id_ok = id_ok | (w[15:0] == oam_ids_in[i]);
    end
    // Their source direction is our receive direction
    bad_cfg = s.rssi != uom_ssi(ssi_en_in, slots_in, pdus_in) || s.rbids != {rx_bid_in, tx_bid_in};

    if (s.tick >= uom_tick_last(ts_coarse_in)) begin
      next_s.tick = 12'h000;
      next_s.ts = s.ts + 32'h1;
    end else begin
      next_s.tick = s.tick + 12'h001;
    end

    case (s.widx)
      W_ETH: word = {ethertype_in, s.bid};
      W_VLAN: word = vlan_tag_in;
      W_CTRL: word = uom_ctrl_word(flags_in, s.dly);
      W_SEQ: word = {s.seq, `UOM_TYPE_REPLY, s.code};
      W_SSI: word = uom_ssi(ssi_en_in, slots_in, pdus_in);
      W_BID: word = {tx_bid_in, rx_bid_in};
      W_TS0: word = s.ts0;
      W_TS1: word = s.ts1;
      W_TS2: word = s.ts2;
      default: word = ~s.crc;
    endcase

    // Same two-entry buffer and stall as the query end
    pop = s.tx_valid && link.r2q_ready;
    push = s.bld && (s.cnt != 2'h2 || pop);
    if (pop) begin
      next_s.buff[0] = s.buff[1];
      next_s.cnt = s.cnt - 2'h1;
    end
    if (push) begin
      next_s.buff[next_s.cnt[0]] = {s.widx == W_CRC, word};
      next_s.cnt = next_s.cnt + 2'h1;
      next_s.crc = uom_crc(s.crc, word);
      next_s.widx = uom_next_word(s.widx, vlan_en_in, s.dly);
      if (s.widx == W_CRC) begin
        next_s.bld = 1'h0;
      end
    end
    next_s.tx_valid = next_s.cnt != 2'h0;

    // Query parser
    if (link.q2r_valid && s.rx_ready) begin
      case (s.ridx)
        W_ETH: begin
          next_s.rbad = !id_ok || w[31:16] != ethertype_in;
          next_s.rbid = w[15:0];
          next_s.rts_rx = s.ts;
        end
        W_CTRL: next_s.rdly = w[15:0] == `UOM_LEN_DELAY;
        W_SEQ: next_s.rw1 = w;
        W_SSI: next_s.rssi = w;
        W_BID: next_s.rbids = w;
        W_TS0: next_s.rts0 = w;
        W_CRC: begin
          // A query that lands while a reply is still going out is dropped
          if (!s.rbad && w == ~s.rcrc && s.rw1[15:8] == `UOM_TYPE_QUERY && !s.bld) begin
            next_s.query_valid = 1'h1;
            next_s.query_seq = s.rw1[31:16];
            next_s.mismatch = bad_cfg;
            next_s.bld = 1'h1;
            next_s.widx = W_ETH;
            next_s.crc = `UOM_CRC_INIT;
            next_s.bid = s.rbid;
            next_s.seq = s.rw1[31:16];
            next_s.dly = s.rdly;
            next_s.ts0 = s.rts0;
            next_s.ts1 = s.rts_rx;
            next_s.ts2 = s.ts;
            next_s.code = (s.rw1[7:0] == `UOM_QCODE_VALIDATE && bad_cfg) ? `UOM_RCODE_INVALID : `UOM_RCODE_ACK;
          end
        end
        default: ;
      endcase
      next_s.rcrc = uom_crc(s.rcrc, w);
      next_s.ridx = uom_next_word(s.ridx, vlan_en_in, next_s.rdly);
      if (link.q2r_last) begin
        next_s.ridx = W_ETH;
        next_s.rcrc = `UOM_CRC_INIT;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
      s.rcrc <= `UOM_CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  assign link.r2q_data = s.buff[0][31:0];
  assign link.r2q_last = s.buff[0][32];
  assign link.r2q_valid = s.tx_valid;
  assign link.q2r_ready = s.rx_ready;
  assign query_valid_out = s.query_valid;
  assign mismatch_out = s.mismatch;
  assign query_seq_out = s.query_seq;

endmodule // uom_reply_end

`default_nettype wire

// >>> dv/uom_link_properties.sv
// Assertions on the link joining the query end and the reply end.
// Assumes a VLAN tag, when present, has a nonzero top nibble.
`timescale 1ns/1ps
`default_nettype none

module uom_link_properties (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [31:0] q2r_data,
  input wire logic q2r_last,
  input wire logic q2r_valid,
  input wire logic q2r_ready,
  input wire logic [31:0] r2q_data,
  input wire logic r2q_last,
  input wire logic r2q_valid,
  input wire logic r2q_ready
);
  logic [3:0] qi, ri;
  logic qo, ro;
  logic [15:0] qseq, qbid, qlen;
  wire logic q_take = q2r_valid && q2r_ready;
  wire logic r_take = r2q_valid && r2q_ready;
  wire logic q_end = q_take && q2r_last;
  wire logic [3:0] qs = 4'h2 + {3'h0, qo};
  wire logic [3:0] rs = 4'h2 + {3'h0, ro};
  // Control word sits after the optional tag; a tag never starts with a zero nibble
  wire logic q_ctrl = (qi == 4'h1 && q2r_data[31:28] == 4'h0) || (qi == 4'h2 && qo);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  // Word position in each direction, and query fields the query and the reply are judged against
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      qi <= 4'h0;
      ri <= 4'h0;
      qo <= 1'b0;
      ro <= 1'b0;
      qseq <= 16'h0000;
      qbid <= 16'h0000;
      qlen <= 16'h0000;
    end else begin
      if (q_take) qi <= q2r_last ? 4'h0 : qi + 4'h1;
      if (r_take) ri <= r2q_last ? 4'h0 : ri + 4'h1;
      if (q_take && qi == 4'h1) qo <= q2r_data[31:28] != 4'h0;
      if (r_take && ri == 4'h1) ro <= r2q_data[31:28] != 4'h0;
      if (q_take && qi == 4'h0) qbid <= q2r_data[15:0];
      if (q_take && q_ctrl) qlen <= q2r_data[15:0];
      if (q_take && qi == qs) qseq <= q2r_data[31:16];
    end
  end

  ready_after_reset_a: assert property ($past(resetn_in) |-> q2r_ready && r2q_ready)
    else $error("link ready low after reset");
  query_type_a: assert property (q_take && qi == qs |-> q2r_data[15:8] == 8'h00)
    else $error("query type wrong");
  reply_type_a: assert property (r_take && ri == rs |-> r2q_data[15:8] == 8'h08)
    else $error("reply type wrong");
  query_code_a: assert property (q_take && qi == qs |-> q2r_data[7:1] == 7'h00)
    else $error("query code out of range");
  reply_code_a: assert property (r_take && ri == rs |-> r2q_data[7:1] == 7'h00)
    else $error("reply code out of range");
  seq_step_a: assert property (q_take && qi == qs |-> q2r_data[31:16] == qseq + 16'h0001)
    else $error("query sequence did not step by one");
  seq_echo_a: assert property (r_take && ri == rs |-> r2q_data[31:16] == qseq)
    else $error("reply sequence not echoed");
  query_len_a: assert property (q_end |-> qi == (qlen == 16'h001C ? 4'h8 : 4'h5) + {3'h0, qo})
    else $error("length field disagrees with word count");
  reply_bid_a: assert property (r_take && ri == 4'h0 |-> r2q_data[15:0] == qbid)
    else $error("reply identifier differs from query");
  reply_start_a: assert property ($rose(r2q_valid) |-> $past(q_end, 2))
    else $error("reply did not start two cycles after query end");

  cover property (q_end && qlen == 16'h001C);
  cover property (q_take && qi == qs && q2r_data[7:0] == 8'h01);
  cover property (r_take && ri == rs && r2q_data[7:0] == 8'h01);
endmodule // uom_link_properties

`default_nettype wire

// >>> dv/udp_ip_oam_message_format_test.sv
// Self-checking bench: query end and reply end joined by the link interface.
// Assumes one 40 MHz clock and one active-low reset shared by both ends.
`timescale 1ns/1ps
`default_nettype none
`include "uom_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module udp_ip_oam_message_format_test;
  import uom_pkg::*;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic start = 1'b0, validate = 1'b1, delay_en = 1'b0, ts_coarse = 1'b0, ssi_en = 1'b0, vlan_en = 1'b0;
  logic [15:0] oam_bid = 16'h03F2, q_tx = 16'h0011, q_rx = 16'h0022, r_rx = 16'h0011;
  logic [7:0] r_slots = 8'h18;
  logic busy, reply_valid, reply_code, seq_err, query_valid, mismatch, got_q, got_r, q_mis;
  logic [15:0] reply_seq, query_seq, q_seq, exp_seq;
  logic [31:0] ts_src_tx, ts_dst_rx, ts_dst_tx, ts_src_rx;
  int n_fail = 0, n_checks = 0, cyc = 0;
  // Shared bundle settings and per-end flags; driven from the bench so scenarios can vary them
  logic [7:0] pdus = 8'h08;
  logic [15:0] ethertype = 16'h0800;
  logic [31:0] vlan_tag = 32'h8100_0123;
  uom_flags_s q_flags = uom_flags_s'(4'hA), r_flags = uom_flags_s'(4'h5);
  logic [3:0] q_word, r_word;
  logic [31:0] q_ctrl, r_ctrl, r_ssi, r_bids;

  // Clock and a cycle count since reset release for stamp expectations
  always #12.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc <= resetn_in ? cyc + 1 : 0;

  // Words taken on the link, indexed from each message start; the optional tag shifts them
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_word <= 4'h0;
      r_word <= 4'h0;
    end else begin
      if (uom_link_if_inst.q2r_valid && uom_link_if_inst.q2r_ready) begin
        q_word <= uom_link_if_inst.q2r_last ? 4'h0 : q_word + 4'h1;
        if (q_word == 4'h1 + {3'h0, vlan_en}) q_ctrl <= uom_link_if_inst.q2r_data;
      end
      if (uom_link_if_inst.r2q_valid && uom_link_if_inst.r2q_ready) begin
        r_word <= uom_link_if_inst.r2q_last ? 4'h0 : r_word + 4'h1;
        if (r_word == 4'h1 + {3'h0, vlan_en}) r_ctrl <= uom_link_if_inst.r2q_data;
        if (r_word == 4'h3 + {3'h0, vlan_en}) r_ssi <= uom_link_if_inst.r2q_data;
        if (r_word == 4'h4 + {3'h0, vlan_en}) r_bids <= uom_link_if_inst.r2q_data;
      end
    end
  end

  uom_link_if uom_link_if_inst ();
  uom_query_end uom_query_end_inst (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .link(uom_link_if_inst.query_end), .start_in(start), .validate_in(validate), .delay_en_in(delay_en),
    .ts_coarse_in(ts_coarse), .flags_in(q_flags), .oam_bid_in(oam_bid), .tx_bid_in(q_tx),
    .rx_bid_in(q_rx), .ssi_en_in(ssi_en), .slots_in(8'h18), .pdus_in(pdus), .ethertype_in(ethertype),
    .vlan_en_in(vlan_en), .vlan_tag_in(vlan_tag), .busy_out(busy), .reply_valid_out(reply_valid),
    .reply_code_out(reply_code), .reply_seq_out(reply_seq), .seq_err_out(seq_err), .ts_src_tx_out(ts_src_tx),
    .ts_dst_rx_out(ts_dst_rx), .ts_dst_tx_out(ts_dst_tx), .ts_src_rx_out(ts_src_rx));
  uom_reply_end uom_reply_end_inst (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .link(uom_link_if_inst.reply_end), .ts_coarse_in(ts_coarse), .flags_in(r_flags),
    .oam_ids_in({16'h03F3, 16'h03F2, 16'h03F1, 16'h03F0}), .tx_bid_in(q_rx), .rx_bid_in(r_rx),
    .ssi_en_in(ssi_en), .slots_in(r_slots), .pdus_in(pdus), .ethertype_in(ethertype), .vlan_en_in(vlan_en),
    .vlan_tag_in(vlan_tag), .query_valid_out(query_valid), .mismatch_out(mismatch),
    .query_seq_out(query_seq));
  uom_link_properties uom_link_properties_inst (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .q2r_data(uom_link_if_inst.q2r_data), .q2r_last(uom_link_if_inst.q2r_last),
    .q2r_valid(uom_link_if_inst.q2r_valid), .q2r_ready(uom_link_if_inst.q2r_ready),
    .r2q_data(uom_link_if_inst.r2q_data), .r2q_last(uom_link_if_inst.r2q_last),
    .r2q_valid(uom_link_if_inst.r2q_valid), .r2q_ready(uom_link_if_inst.r2q_ready));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset also restarts the query sequence and both stamp clocks
  task automatic do_reset(input logic coarse);
    resetn_in = 1'b0;
    ts_coarse = coarse;
    exp_seq = 16'h0000;
    repeat (10) @(negedge sys_clk_in);
    resetn_in = 1'b1;
  endtask

  // One query; pulses last one cycle, so both are caught inside the bounded wait
  task automatic do_query(input logic val, input logic dly);
    got_q = 1'b0;
    got_r = 1'b0;
    exp_seq = exp_seq + 16'h0001;
    @(negedge sys_clk_in);
    validate = val;
    delay_en = dly;
    start = 1'b1;
    @(negedge sys_clk_in);
    start = 1'b0;
    `CHK("busy", 1'b1, busy)
    for (int i = 0; i < 80 && !got_r; i++) begin
      @(negedge sys_clk_in);
      if (query_valid === 1'b1) begin
        got_q = 1'b1;
        q_mis = mismatch;
        q_seq = query_seq;
      end
      got_r = reply_valid === 1'b1;
    end
  endtask

  task automatic chk_reply(input logic code, input logic mis);
    `CHK("query pulse", 1'b1, got_q)
    `CHK("reply pulse", 1'b1, got_r)
    `CHK("query seq", exp_seq, q_seq)
    `CHK("reply seq", exp_seq, reply_seq)
    `CHK("seq error", 1'b0, seq_err)
    `CHK("mismatch", mis, q_mis)
    `CHK("reply code", code, reply_code)
    `CHK("query flags", q_flags, q_ctrl[27:24])
    `CHK("reply flags", r_flags, r_ctrl[27:24])
    `CHK("reply length", delay_en ? `UOM_LEN_DELAY : `UOM_LEN_BASIC, r_ctrl[15:0])
    `CHK("reply service", ssi_en ? {pdus, r_slots, 16'h0000} : 32'h0, r_ssi)
    `CHK("reply ids", {q_rx, r_rx}, r_bids)
  endtask

  task automatic t_basic();
    do_query(1'b1, 1'b0);
    chk_reply(1'b0, 1'b0);
    `CHK("no stamps", 32'h0, ts_src_tx | ts_dst_rx | ts_dst_tx | ts_src_rx)
  endtask

  // Service field mismatch with and without validation, identifier mismatch with validation
  task automatic t_codes();
    ssi_en = 1'b1;
    r_slots = 8'h20;
    do_query(1'b0, 1'b0);
    chk_reply(1'b0, 1'b1);
    do_query(1'b1, 1'b0);
    chk_reply(1'b1, 1'b1);
    r_slots = 8'h18;
    do_query(1'b1, 1'b0);
    chk_reply(1'b0, 1'b0);
    r_rx = 16'h0033;
    do_query(1'b1, 1'b0);
    chk_reply(1'b1, 1'b1);
    r_rx = 16'h0011;
    ssi_en = 1'b0;
  endtask

  // Identifier outside the reserved table is dropped; the next good one answers
  task automatic t_bad_id();
    oam_bid = 16'h0400;
    do_query(1'b1, 1'b0);
    `CHK("dropped query", 1'b0, got_q)
    `CHK("dropped reply", 1'b0, got_r)
    oam_bid = 16'h03F0;
    do_query(1'b1, 1'b0);
    chk_reply(1'b0, 1'b0);
  endtask

  task automatic t_vlan();
    vlan_en = 1'b1;
    q_flags = uom_flags_s'(4'h3);
    do_query(1'b1, 1'b1);
    chk_reply(1'b0, 1'b0);
    vlan_en = 1'b0;
  endtask

  task automatic t_delay(input logic coarse, input int idle, input int tick);
    int t0;
    do_reset(coarse);
    repeat (idle) @(negedge sys_clk_in);
    t0 = cyc / tick;
    do_query(1'b1, 1'b1);
    chk_reply(1'b0, 1'b0);
    `CHK("src stamp", 1'b1, ts_src_tx >= t0 && ts_src_tx <= t0 + 1)
    `CHK("stamp order", 1'b1, ts_dst_rx >= ts_src_tx && ts_dst_tx >= ts_dst_rx && ts_src_rx >= ts_dst_tx)
  endtask

  initial begin
    do_reset(1'b0);
    t_basic();
    t_codes();
    t_bad_id();
    t_vlan();
    t_delay(1'b0, 200, 40);
    t_delay(1'b1, 8100, 4000);
    end_sim();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    n_fail++;
    end_sim();
  end
endmodule // udp_ip_oam_message_format_test

`default_nettype wire
